// file: hw/rpc_defs.vh
// Constants for the RGB pulse-count LED control block
`ifndef RPC_DEFS_VH
`define RPC_DEFS_VH

`define RPC_CLK_MHZ        100
`define RPC_OSC_KHZ        900
`define RPC_SHUTDOWN_US    350
`define RPC_DROPOUT_US     140
`define RPC_SOFT_US        100
`define RPC_RAMP_STEPS     16
`define RPC_TIMER_W        16

`define RPC_COUNT_W        3
`define RPC_COUNT_WHITE    3'h7

`define RPC_COEF_W         11
`define RPC_COEF_GREEN     11'h6f0
`define RPC_COEF_RED       11'h63e
`define RPC_COEF_BLUE      11'h534

`define RPC_ADDR_CTRL      8'h00
`define RPC_ADDR_STATUS    8'h04
`define RPC_CTRL_MASK_RST  3'h7

`define RPC_ST_SHUTDOWN_BIT 0
`define RPC_ST_COUNT_LSB    8
`define RPC_ST_WHITE_BIT    11
`define RPC_ST_DOUBLER_BIT  12
`define RPC_ST_OVER_BIT     13
`define RPC_ST_DRV_LSB      16

`endif

// file: hw/rpc_persist_timer.v
// Persistence filter: asserts once a level has held for LIMIT cycles
`timescale 1ns/10ps
`include "rpc_defs.vh"
module rpc_persist_timer #(
    parameter WIDTH = `RPC_TIMER_W,
    parameter LIMIT = 1
) (
    input  wire             ref_clk,
    input  wire             sys_rst,
    input  wire             level,
    output reg              expired
);
    localparam integer     LAST_I = LIMIT - 1;
    localparam [WIDTH-1:0] LAST   = LAST_I[WIDTH-1:0];

    reg [WIDTH-1:0] count;

    // Any drop of the level restarts the wait, so glitches never add up
    always @(posedge ref_clk) begin
        if (sys_rst || !level) begin
            count   <= {WIDTH{1'b0}};
            expired <= 1'b0;
        end else if (count == LAST) begin
            expired <= 1'b1;
        end else begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

// file: hw/rpc_led_control.v
// Control logic of a three-channel RGB LED driver with charge pump
// Operation
// - Rising enable edges advance internal pulse counter.
// - Counts one to six select colour channels.
// - Seven or more pulses select white mode.
// - White mode scales currents from green input.
// - Low for 350 us forces full shutdown.
// - Shutdown stops pump, oscillator and drivers; edge counting continues.
// - Weak pull-down keeps undriven line low.
// - Precharge through weak pull-up before pass-through.
// - Start-up always enters pass-through mode.
// - Dropout moves to doubler through soft-start.
// - Dropout must persist 140 us first.
// - Doubler left only via shutdown and reprogramming.
// - Pump short forces disable and new precharge.
// - Soft-start ramps pump current over 100 us.
// - Programming-input overcurrent shuts LED drivers.
// - Tied red/blue inputs use green programming.
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "rpc_defs.vh"
module rpc_led_control #(
    parameter SHUTDOWN_CYCLES = `RPC_SHUTDOWN_US * `RPC_CLK_MHZ,
    parameter DROPOUT_CYCLES  = `RPC_DROPOUT_US * `RPC_CLK_MHZ,
    parameter SOFT_CYCLES     = `RPC_SOFT_US * `RPC_CLK_MHZ,
    parameter RAMP_STEPS      = `RPC_RAMP_STEPS,
    parameter OSC_HALF_CYCLES = (`RPC_CLK_MHZ * 1000) / (2 * `RPC_OSC_KHZ)
) (
    input  wire                    ref_clk,
    input  wire                    sys_rst,
    input  wire                    programEnableLine,
    output reg                     enableLinePulldownOn,
    input  wire                    pumpNearSupply,
    input  wire                    pumpBelowLow,
    input  wire [2:0]              driverDropout,
    input  wire [2:0]              programOvercurrent,
    input  wire                    redProgramTied,
    input  wire                    blueProgramTied,
    output reg                     redDriverOn,
    output reg                     greenDriverOn,
    output reg                     blueDriverOn,
    output reg                     whiteMode,
    output reg  [`RPC_COEF_W-1:0]  redCoef,
    output reg  [`RPC_COEF_W-1:0]  greenCoef,
    output reg  [`RPC_COEF_W-1:0]  blueCoef,
    output reg                     redFromGreen,
    output reg                     blueFromGreen,
    output reg                     pumpOutputEnable,
    output reg                     weakPullupOn,
    output reg                     passSwitchOn,
    output reg                     doublerOn,
    output reg  [3:0]              softStartLevel,
    output reg                     flyingCapPlus,
    output reg                     flyingCapMinus,
    output reg                     coreActive,
    input  wire                    hsel,
    input  wire [31:0]             haddr,
    input  wire [1:0]              htrans,
    input  wire                    hwrite,
    input  wire [2:0]              hsize,
    input  wire [31:0]             hwdata,
    input  wire                    hready,
    output wire                    hreadyout,
    output wire                    hresp,
    output reg  [31:0]             hrdata
);
    // One-hot states; bit order is the status word's state field
    localparam [5:0] ST_SHUTDOWN  = 6'h01;
    localparam [5:0] ST_PRECHARGE = 6'h02;
    localparam [5:0] ST_SOFT1X    = 6'h04;
    localparam [5:0] ST_RUN1X     = 6'h08;
    localparam [5:0] ST_SOFT2X    = 6'h10;
    localparam [5:0] ST_RUN2X     = 6'h20;

    // Ramp step never shorter than one cycle
    localparam STEP_RAW = SOFT_CYCLES / RAMP_STEPS;
    localparam STEP_CYCLES = (STEP_RAW < 1) ? 1 : STEP_RAW;
    localparam integer STEP_LAST_I = STEP_CYCLES - 1;
    localparam integer OSC_LAST_I  = ((OSC_HALF_CYCLES < 1) ? 1 : OSC_HALF_CYCLES) - 1;
    localparam [15:0]  STEP_LAST   = STEP_LAST_I[15:0];
    localparam [7:0]   OSC_LAST    = OSC_LAST_I[7:0];

    reg  [5:0]              state;
    reg  [5:0]              next_state;
    reg                     linePrev;
    reg  [`RPC_COUNT_W-1:0] pulseCount;
    reg                     doublerLatched;
    reg                     overTrip;
    reg  [15:0]             stepCount;
    reg  [3:0]              rampLevel;
    reg  [7:0]              oscCount;
    reg                     oscPhase;
    reg  [2:0]              driverMask;
    reg                     dataPhaseWrite;
    reg  [7:0]              dataPhaseAddr;

    wire lowExpired;
    wire dropoutExpired;
    wire riseEdge  = programEnableLine & ~linePrev;
    wire inShut    = state[0];
    wire inSoft    = state[2] | state[4];
    wire inRun     = state[3] | state[5];
    wire rampDone  = inSoft && (rampLevel == 4'hf) && (stepCount == STEP_LAST);
    wire isWhite   = (pulseCount == `RPC_COUNT_WHITE);
    wire dropoutHit = |(driverDropout & pulseCount);
    wire addrPhase = hsel & hready & htrans[1];
    // Drivers follow the count only while the pump is up
    wire [2:0] driverSel = pulseCount & driverMask & {3{inRun | inSoft}} & {3{~overTrip}};

    // Line low for the shutdown time
    rpc_persist_timer #(
        .WIDTH (`RPC_TIMER_W),
        .LIMIT (SHUTDOWN_CYCLES)
    ) lowTimer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .level   (~programEnableLine),
        .expired (lowExpired)
    );

    // Dropout only counts while running pass-through
    // dropout filter time
    rpc_persist_timer #(
        .WIDTH (`RPC_TIMER_W),
        .LIMIT (DROPOUT_CYCLES)
    ) dropTimer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .level   (state[3] & dropoutHit),
        .expired (dropoutExpired)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_SHUTDOWN: begin
                if (programEnableLine)
                    next_state = ST_PRECHARGE;
            end
            ST_PRECHARGE: begin
                if (pumpNearSupply && !pumpBelowLow)
                    next_state = doublerLatched ? ST_SOFT2X : ST_SOFT1X;
            end
            ST_SOFT1X: begin
                if (rampDone)
                    next_state = ST_RUN1X;
            end
            ST_RUN1X: begin
                if (dropoutExpired)
                    next_state = ST_SOFT2X;
            end
            ST_SOFT2X: begin
                if (rampDone)
                    next_state = ST_RUN2X;
            end
            ST_RUN2X: begin
                next_state = ST_RUN2X;
            end
            default: begin
                next_state = ST_SHUTDOWN;
            end
        endcase
        if ((inSoft || inRun) && pumpBelowLow)
            next_state = ST_PRECHARGE;
        // long low time wins
        // A rising line must win, or the first pulse is lost
        if (lowExpired && !programEnableLine)
            next_state = ST_SHUTDOWN;
    end

    always @(posedge ref_clk) begin
        if (sys_rst)
            state <= ST_SHUTDOWN;
        else
            state <= next_state;
    end

    // Edge memory resets low, the idle level of the pulled-down line
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            linePrev   <= 1'b0;
            pulseCount <= {`RPC_COUNT_W{1'b0}};
        end else begin
            linePrev <= programEnableLine;
            if (riseEdge && !isWhite)
                pulseCount <= pulseCount + 3'h1;
            // clear on shutdown time
            // Filtered low, not the state, so short lows
            // between pulses never wipe the count
            else if (lowExpired)
                pulseCount <= {`RPC_COUNT_W{1'b0}};
        end
    end

    // Doubler choice and overcurrent trip persist until shutdown
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            doublerLatched <= 1'b0;
            overTrip       <= 1'b0;
        end else begin
            if (state[4])
                doublerLatched <= 1'b1;
            else if (inShut)
                doublerLatched <= 1'b0;
            if (!inShut && (|programOvercurrent))
                overTrip <= 1'b1;
            else if (inShut)
                overTrip <= 1'b0;
        end
    end

    // ramp in equal steps across the soft-start time
    always @(posedge ref_clk) begin
        if (sys_rst || !inSoft) begin
            stepCount <= 16'h0000;
            rampLevel <= 4'h0;
        end else if (stepCount == STEP_LAST) begin
            stepCount <= 16'h0000;
            if (rampLevel != 4'hf)
                rampLevel <= rampLevel + 4'h1;
        end else begin
            stepCount <= stepCount + 16'h0001;
        end
    end

    // Divider flips the pump phase every OSC_LAST+1 cycles
    // oscillator runs only in doubler mode
    always @(posedge ref_clk) begin
        if (sys_rst || !(state[4] || state[5])) begin
            oscCount <= 8'h00;
            oscPhase <= 1'b0;
        end else if (oscCount == OSC_LAST) begin
            oscCount <= 8'h00;
            oscPhase <= ~oscPhase;
        end else begin
            oscCount <= oscCount + 8'h01;
        end
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            enableLinePulldownOn <= 1'b1;
            redDriverOn          <= 1'b0;
            greenDriverOn        <= 1'b0;
            blueDriverOn         <= 1'b0;
            whiteMode            <= 1'b0;
            redCoef              <= `RPC_COEF_GREEN;
            greenCoef            <= `RPC_COEF_GREEN;
            blueCoef             <= `RPC_COEF_GREEN;
            redFromGreen         <= 1'b0;
            blueFromGreen        <= 1'b0;
            pumpOutputEnable     <= 1'b0;
            weakPullupOn         <= 1'b0;
            passSwitchOn         <= 1'b0;
            doublerOn            <= 1'b0;
            softStartLevel       <= 4'h0;
            flyingCapPlus        <= 1'b0;
            flyingCapMinus       <= 1'b0;
            coreActive           <= 1'b0;
        end else begin
            enableLinePulldownOn <= 1'b1;
            // count bits map to red, green, blue
            redDriverOn   <= driverSel[2];
            greenDriverOn <= driverSel[1];
            blueDriverOn  <= driverSel[0];
            whiteMode <= isWhite & ~inShut;
            greenCoef <= `RPC_COEF_GREEN;
            redCoef   <= isWhite ? `RPC_COEF_RED : `RPC_COEF_GREEN;
            blueCoef  <= isWhite ? `RPC_COEF_BLUE : `RPC_COEF_GREEN;
            redFromGreen  <= isWhite | redProgramTied;
            blueFromGreen <= isWhite | blueProgramTied;
            // pump output high impedance in shutdown
            pumpOutputEnable <= ~inShut;
            weakPullupOn <= state[1];
            passSwitchOn <= state[2] | state[3];
            doublerOn    <= state[4] | state[5];
            // Full scale in run; a short restarts the ramp from zero
            softStartLevel <= inSoft ? rampLevel : (inRun ? 4'hf : 4'h0);
            // Non-overlapping is left to the analog switch drivers
            flyingCapPlus  <= (state[4] | state[5]) & oscPhase;
            flyingCapMinus <= (state[4] | state[5]) & ~oscPhase;
            coreActive     <= ~inShut;
        end
    end

    // Bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Write lands at the edge after its address phase, with hwdata
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            dataPhaseWrite <= 1'b0;
            dataPhaseAddr  <= 8'h00;
        end else if (hready) begin
            dataPhaseWrite <= addrPhase & hwrite;
            dataPhaseAddr  <= haddr[7:0];
        end
    end

    // Mask lets software blank channels without reprogramming
    always @(posedge ref_clk) begin
        if (sys_rst)
            driverMask <= `RPC_CTRL_MASK_RST;
        else if (dataPhaseWrite && dataPhaseAddr == `RPC_ADDR_CTRL)
            driverMask <= hwdata[2:0];
    end

    // Read data is taken in the address phase and held until the next read
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= 32'h00000000;
            if (haddr[7:0] == `RPC_ADDR_CTRL) begin
                hrdata[2:0] <= driverMask;
            end else if (haddr[7:0] == `RPC_ADDR_STATUS) begin
                // State, count, white, doubler, trip, driver select
                hrdata[5:0] <= state;
                hrdata[`RPC_ST_COUNT_LSB+2:`RPC_ST_COUNT_LSB] <= pulseCount;
                hrdata[`RPC_ST_WHITE_BIT]   <= isWhite;
                hrdata[`RPC_ST_DOUBLER_BIT] <= doublerLatched;
                hrdata[`RPC_ST_OVER_BIT]    <= overTrip;
                hrdata[`RPC_ST_DRV_LSB+2:`RPC_ST_DRV_LSB] <= driverSel;
            end
        end
    end
endmodule

// file: test/rpc_led_control_properties.sv
// Concurrent checks on the ports of the LED control block
`timescale 1ns/10ps
`include "rpc_defs.vh"
module rpc_led_control_properties #(
    parameter SHUTDOWN_CYCLES = 40,
    parameter DROPOUT_CYCLES  = 20
) (
    input wire                   ref_clk,
    input wire                   sys_rst,
    input wire                   programEnableLine,
    input wire                   enableLinePulldownOn,
    input wire                   pumpBelowLow,
    input wire [2:0]             driverDropout,
    input wire [2:0]             programOvercurrent,
    input wire                   redProgramTied,
    input wire                   redDriverOn,
    input wire                   greenDriverOn,
    input wire                   blueDriverOn,
    input wire                   whiteMode,
    input wire [`RPC_COEF_W-1:0] redCoef,
    input wire [`RPC_COEF_W-1:0] blueCoef,
    input wire                   redFromGreen,
    input wire                   pumpOutputEnable,
    input wire                   weakPullupOn,
    input wire                   passSwitchOn,
    input wire                   doublerOn,
    input wire [3:0]             softStartLevel,
    input wire                   flyingCapPlus,
    input wire                   flyingCapMinus,
    input wire                   coreActive
);
    int  lowCnt;
    int  dropCnt;
    wire anyDrv = redDriverOn | greenDriverOn | blueDriverOn;
    // Saturating run lengths of line low and of dropout
    always @(posedge ref_clk) begin
        lowCnt <= (sys_rst || programEnableLine) ? 0 : (lowCnt < 100000 ? lowCnt + 1 : lowCnt);
        dropCnt <= (sys_rst || driverDropout == 3'h0) ? 0 : (dropCnt < 100000 ? dropCnt + 1 : dropCnt);
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_off_when_down; !coreActive |-> !pumpOutputEnable && !anyDrv; endproperty
    a_off_when_down: assert property (p_off_when_down) else $error("outputs live in shutdown");
    property p_low_shuts; lowCnt >= SHUTDOWN_CYCLES + 3 |-> !coreActive; endproperty
    a_low_shuts: assert property (p_low_shuts) else $error("no shutdown after long low");
    property p_pulldown; enableLinePulldownOn; endproperty
    a_pulldown: assert property (p_pulldown) else $error("line pull-down off");
    property p_white_mix; whiteMode && $past(whiteMode) |-> redCoef == 11'h63e && blueCoef == 11'h534; endproperty
    a_white_mix: assert property (p_white_mix) else $error("white mix coefficients wrong");
    property p_precharge_first; $rose(passSwitchOn) |-> $past(weakPullupOn) && !doublerOn; endproperty
    a_precharge_first: assert property (p_precharge_first) else $error("1x entered without precharge");
    property p_stay_1x; passSwitchOn && dropCnt < DROPOUT_CYCLES - 2 |=> !doublerOn; endproperty
    a_stay_1x: assert property (p_stay_1x) else $error("doubler before filter time");
    property p_doubler_kept; $fell(doublerOn) |-> weakPullupOn || !coreActive; endproperty
    a_doubler_kept: assert property (p_doubler_kept) else $error("doubler left while running");
    property p_short; pumpBelowLow && (passSwitchOn || doublerOn) |-> ##[1:4] weakPullupOn; endproperty
    a_short: assert property (p_short) else $error("no precharge after pump short");
    property p_overcurrent; (|programOvercurrent) [*2] |-> ##[0:3] !anyDrv; endproperty
    a_overcurrent: assert property (p_overcurrent) else $error("drivers on in overcurrent");
    property p_soft_step; softStartLevel > $past(softStartLevel) |-> softStartLevel - $past(softStartLevel) == 4'h1;
    endproperty
    a_soft_step: assert property (p_soft_step) else $error("soft-start level jumped");
    property p_tied; redProgramTied [*3] |-> redFromGreen; endproperty
    a_tied: assert property (p_tied) else $error("tied red not set from green");
    property p_caps; flyingCapPlus || flyingCapMinus |-> !(flyingCapPlus && flyingCapMinus) && doublerOn;
    endproperty
    a_caps: assert property (p_caps) else $error("flying cap phases wrong");
    c_white_doubler: cover property (whiteMode && doublerOn);
    c_short_in_doubler: cover property (pumpBelowLow && doublerOn);
    c_tied_run: cover property (redFromGreen && redDriverOn);
endmodule
bind rpc_led_control rpc_led_control_properties #(
    .SHUTDOWN_CYCLES(SHUTDOWN_CYCLES), .DROPOUT_CYCLES(DROPOUT_CYCLES)) i_props (
    .ref_clk, .sys_rst, .programEnableLine, .enableLinePulldownOn, .pumpBelowLow, .driverDropout,
    .programOvercurrent, .redProgramTied, .redDriverOn, .greenDriverOn, .blueDriverOn, .whiteMode, .redCoef,
    .blueCoef, .redFromGreen, .pumpOutputEnable, .weakPullupOn, .passSwitchOn, .doublerOn, .softStartLevel,
    .flyingCapPlus, .flyingCapMinus, .coreActive);

// file: test/rpc_host_model.sv
// Host model driving the single enable and programming line
`timescale 1ns/10ps
module rpc_host_model #(
    parameter LOW_HOLD = 50
) (
    input  wire ref_clk,
    output reg  programEnableLine
);
    initial programEnableLine = 1'b0;
    task automatic program_pulses(input int n, input int w);
        programEnableLine <= 1'b0;
        repeat (LOW_HOLD) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            programEnableLine <= 1'b1;
            repeat (w) @(posedge ref_clk);
            if (i < n - 1) begin
                programEnableLine <= 1'b0;
                repeat (w) @(posedge ref_clk);
            end
        end
    endtask
    // Released line sinks to pull-down level
    task automatic release_line();
        programEnableLine <= 1'b0;
    endtask
endmodule

// file: test/test_rpc_led_control.sv
// Self-checking bench for the LED control block
`timescale 1ns/10ps
module test_rpc_led_control;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, pumpNearSupply = 1'b0, pumpBelowLow = 1'b0;
    logic        redProgramTied = 1'b0, blueProgramTied = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  driverDropout = 3'h0, programOvercurrent = 3'h0, hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    wire         programEnableLine, enableLinePulldownOn, redDriverOn, greenDriverOn, blueDriverOn, whiteMode;
    wire         redFromGreen, blueFromGreen, pumpOutputEnable, weakPullupOn, passSwitchOn, doublerOn;
    wire         flyingCapPlus, flyingCapMinus, coreActive, hreadyout, hresp;
    wire [3:0]   softStartLevel;
    wire [10:0]  redCoef, greenCoef, blueCoef;
    wire [31:0]  hrdata;
    wire [2:0]   drv = {redDriverOn, greenDriverOn, blueDriverOn};
    int          nFail = 0, testsRun = 0;
    rpc_led_control #(.SHUTDOWN_CYCLES(40), .DROPOUT_CYCLES(20), .SOFT_CYCLES(32), .RAMP_STEPS(16))
    i_rpc_led_control (
        .ref_clk, .sys_rst, .programEnableLine, .enableLinePulldownOn, .pumpNearSupply, .pumpBelowLow,
        .driverDropout, .programOvercurrent, .redProgramTied, .blueProgramTied, .redDriverOn, .greenDriverOn,
        .blueDriverOn, .whiteMode, .redCoef, .greenCoef, .blueCoef, .redFromGreen, .blueFromGreen,
        .pumpOutputEnable, .weakPullupOn, .passSwitchOn, .doublerOn, .softStartLevel, .flyingCapPlus,
        .flyingCapMinus, .coreActive, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata);
    rpc_host_model #(.LOW_HOLD(50)) i_rpc_host_model (.ref_clk, .programEnableLine);
    always #5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        testsRun++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            nFail++;
        end
    endtask
    task automatic conclude();
        if (nFail == 0 && testsRun > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Single transfer; waits on hready in both phases
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic expect_rd(input string nm, input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(nm, e, rd & m);
        chk("okay", 0, hresp);
    endtask
    task automatic wait_run();
        int t;
        t = 0;
        while (!(softStartLevel === 4'hf && (passSwitchOn | doublerOn) === 1'b1) && t < 400) begin
            @(posedge ref_clk);
            t++;
        end
        chk("runReached", 1, t < 400);
        repeat (2) @(posedge ref_clk);
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk);
        nFail++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        expect_rd("ctrlReset", 32'h0, 32'hffffffff, 32'h7);
        expect_rd("statusReset", 32'h4, 32'h7ff, 32'h1);
        chk("pulldown", 1, enableLinePulldownOn);
        chk("pumpHiZ", 0, pumpOutputEnable);
        bus(32'h10, 1'b1, 32'h0);
        expect_rd("unmapped", 32'h10, 32'hffffffff, 32'h0);
        expect_rd("ctrlKept", 32'h0, 32'hffffffff, 32'h7);
        for (int n = 1; n <= 8; n++) begin
            pumpNearSupply <= 1'b0;
            i_rpc_host_model.program_pulses(n, 1 + n % 2);
            repeat (5) @(posedge ref_clk);
            chk("precharge", 2'b10, {weakPullupOn, passSwitchOn});
            pumpNearSupply <= 1'b1;
            wait_run();
            chk("startMode", 2'b10, {passSwitchOn, doublerOn});
            chk("drivers", n >= 7 ? 7 : n, drv);
            chk("white", n >= 7, whiteMode);
            chk("fromGreen", {2{n >= 7}}, {redFromGreen, blueFromGreen});
            expect_rd("count", 32'h4, 32'h700, (n >= 7 ? 7 : n) << 8);
        end
        chk("coefs", {11'h6f0, 11'h63e, 11'h534}, {greenCoef, redCoef, blueCoef});
        driverDropout <= 3'h2;
        repeat (10) @(posedge ref_clk);
        driverDropout <= 3'h0;
        repeat (30) @(posedge ref_clk);
        chk("glitchFiltered", 0, doublerOn);
        driverDropout <= 3'h2;
        repeat (25) @(posedge ref_clk);
        wait_run();
        chk("doubler", 1, doublerOn);
        chk("capsSwing", 1, flyingCapPlus ^ flyingCapMinus);
        driverDropout <= 3'h0;
        repeat (50) @(posedge ref_clk);
        chk("doublerKept", 1, doublerOn);
        pumpBelowLow <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("shortPull", 1, weakPullupOn);
        chk("shortOff", 0, drv);
        pumpBelowLow <= 1'b0;
        repeat (3) @(posedge ref_clk);
        wait_run();
        chk("doublerAfterShort", 1, doublerOn);
        programOvercurrent <= 3'h4;
        repeat (3) @(posedge ref_clk);
        chk("overOff", 0, drv);
        expect_rd("overFlag", 32'h4, 32'h2000, 32'h2000);
        programOvercurrent <= 3'h0;
        bus(32'h0, 1'b1, 32'h4);
        i_rpc_host_model.program_pulses(6, 1);
        wait_run();
        chk("masked", 4, drv);
        chk("backTo1x", 2'b10, {passSwitchOn, doublerOn});
        redProgramTied <= 1'b1;
        blueProgramTied <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("fromGreen", 3, {redFromGreen, blueFromGreen});
        i_rpc_host_model.release_line();
        repeat (60) @(posedge ref_clk);
        chk("shutdown", 0, {coreActive, pumpOutputEnable});
        expect_rd("countCleared", 32'h4, 32'h701, 32'h1);
        conclude();
    end
endmodule
